// ### hw/dclq_pkg.sv
// constants shared by the look-ahead queue and its storage buffer
// assumes a single clock and a user that drives write and read strobes
//
// Overview of operation
// - two read modes: standard or look-ahead, build-time
// - look-ahead loads output register without read
// - first word after empty appears unasked
// - read acknowledges word; next word replaces it
// - independent read strobe crossed internally, any phase
// - common clock build has no synchroniser
// - width conversion from 1:8 to 8:1
// - unequal widths only with block memory, independent
// - output pipeline delays data and valid one cycle
// - look-ahead reuses pipeline register as output
// - pipeline build resets data output to value
// - optional error injection and correction on words, block memory only
// - full, almost full, empty, almost empty, handshakes
// - read side and write side both follow clk timing
// - build-time choice of synchronous or asynchronous reset
`default_nettype none

package dclq_pkg;

   typedef enum logic {
      DCLQ_STANDARD,
      DCLQ_LOOK_AHEAD
   } dclq_mode_t;

   localparam int unsigned DCLQ_DEF_DEPTH   = 16;
   localparam int unsigned DCLQ_DEF_WR_W    = 8;
   localparam int unsigned DCLQ_DEF_RD_W    = 8;
   localparam int unsigned DCLQ_MAX_RATIO   = 8;
   localparam int unsigned DCLQ_PIECE_W     = 3;
   localparam int unsigned DCLQ_AFULL_GAP   = 1;
   localparam int unsigned DCLQ_AEMPTY_GAP  = 1;
   localparam logic [31:0] DCLQ_DOUT_RST    = 32'h0000_0000;
   localparam logic        DCLQ_EMPTY_RST   = 1'b1;
   localparam int unsigned DCLQ_SYNC_STAGES = 3;

endpackage

`default_nettype wire

// ### hw/dclq_fifo.sv
// storage buffer of the queue: flip-flop memory with valid/ready on both sides
// assumes the caller holds ce low to freeze it and keeps widths consistent
`default_nettype none

module dclq_fifo
   import dclq_pkg::*;
#(
   parameter int unsigned W        = 8,
   parameter int unsigned DEPTH    = DCLQ_DEF_DEPTH,
   parameter bit          ASYNC_RS = 1'b0,
   localparam int unsigned AW      = $clog2(DEPTH),
   localparam int unsigned CW      = $clog2(DEPTH + 1)
)(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   input  wire logic          in_valid,
   output logic               in_ready,
   input  wire logic [W-1:0]  in_data,
   output logic               out_valid,
   input  wire logic          out_ready,
   output logic [W-1:0]       out_data,
   output logic [CW-1:0]      count
);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [CW-1:0]           cnt;
   } dclq_buf_t;

   dclq_buf_t st_q;
   dclq_buf_t st_d;
   logic      push;
   logic      pop;

   ////////////////////////////////////////////////////////////////////////////

   assign in_ready  = (st_q.cnt != CW'(DEPTH));
   assign out_valid = (st_q.cnt != '0);
   assign out_data  = st_q.mem[st_q.rp];
   assign count     = st_q.cnt;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      st_d = st_q;
      if (ce) begin
         if (push) begin
            st_d.mem[st_q.wp] = in_data;
            st_d.wp = (st_q.wp == AW'(DEPTH - 1)) ? '0 : st_q.wp + 1'b1;
         end
         if (pop) begin
            st_d.rp = (st_q.rp == AW'(DEPTH - 1)) ? '0 : st_q.rp + 1'b1;
         end
         st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   generate
      if (ASYNC_RS) begin : g_arst
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               st_q <= '0;
            end else begin
               st_q <= st_d;
            end
         end
      end else begin : g_srst
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               st_q <= '0;
            end else begin
               st_q <= st_d;
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ### hw/dclq_top.sv
// look-ahead queue: width conversion, read modes, output pipeline, ecc, flags
// assumes strobes from logic on clk, or with INDEP_RD a read strobe
// from a foreign domain held high for several clk cycles per request
`default_nettype none

module dclq_top
   import dclq_pkg::*;
#(
   parameter int unsigned WR_W      = DCLQ_DEF_WR_W,
   parameter int unsigned RD_W      = DCLQ_DEF_RD_W,
   parameter int unsigned DEPTH     = DCLQ_DEF_DEPTH,
   parameter dclq_mode_t  MODE      = DCLQ_STANDARD,
   parameter bit          OUT_REG   = 1'b0,
   parameter bit          ECC_ON    = 1'b0,
   parameter bit          MEM_BLOCK = 1'b1,
   parameter bit          INDEP_RD  = 1'b0,
   parameter bit          ASYNC_RS  = 1'b0,
   parameter logic [RD_W-1:0] DOUT_RST_VAL = RD_W'(DCLQ_DOUT_RST)
)(
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            ce,
   input  wire logic            wr_en,
   input  wire logic [WR_W-1:0] wr_data,
   input  wire logic            inj_sbit,
   input  wire logic            inj_dbit,
   input  wire logic            rd_en,
   output logic      [RD_W-1:0] rd_data,
   output logic                 valid,
   output logic                 full,
   output logic                 almost_full,
   output logic                 empty,
   output logic                 almost_empty,
   output logic                 wr_ack,
   output logic                 overflow,
   output logic                 underflow,
   output logic                 sbit_err,
   output logic                 dbit_err
);

   ////////////////////////////////////////////////////////////////////////////
   // build-time geometry

   // conversion only where block memory and an independent read side exist
   localparam bit NONSYM = MEM_BLOCK && INDEP_RD;
   localparam int unsigned RW_RAT = (NONSYM && RD_W > WR_W) ? RD_W / WR_W : 1;
   localparam int unsigned RR_RAT = (NONSYM && WR_W > RD_W) ? WR_W / RD_W : 1;
   localparam int unsigned SW = (WR_W > RD_W) ? WR_W : RD_W;
   localparam bit          ECC = ECC_ON && MEM_BLOCK;
   localparam int unsigned EW = ECC ? 2 * (SW + 1) : SW;
   localparam int unsigned CW = $clog2(DEPTH + 1);
   localparam bit          LOOK = (MODE == DCLQ_LOOK_AHEAD);
   localparam bit          PIPE = OUT_REG && !LOOK;
   localparam logic [RD_W-1:0] RST_OUT = OUT_REG ? DOUT_RST_VAL : '0;
   localparam logic [DCLQ_PIECE_W-1:0] W_LAST = DCLQ_PIECE_W'(RW_RAT - 1);
   localparam logic [DCLQ_PIECE_W-1:0] R_LAST = DCLQ_PIECE_W'(RR_RAT - 1);

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [DCLQ_SYNC_STAGES-1:0] sy;
      logic                        rq_lvl;
      logic [SW-1:0]               asm_w;
      logic [DCLQ_PIECE_W-1:0]     wc;
      logic [DCLQ_PIECE_W-1:0]     pc;
      logic [RD_W-1:0]             hold;
      logic                        hv;
      logic [RD_W-1:0]             dout;
      logic                        vld;
      logic                        full;
      logic                        afull;
      logic                        empty;
      logic                        aempty;
      logic                        wack;
      logic                        ovf;
      logic                        unf;
      logic                        sbe;
      logic                        dbe;
   } dclq_st_t;

   localparam dclq_st_t ST_RST = '{
      hold:   RST_OUT,
      dout:   RST_OUT,
      empty:  DCLQ_EMPTY_RST,
      aempty: DCLQ_EMPTY_RST,
      default: '0
   };

   dclq_st_t        st_q;
   dclq_st_t        st_d;
   logic            f_in_valid;
   logic            f_in_ready;
   logic [EW-1:0]   f_in_data;
   logic            f_out_valid;
   logic            f_out_ready;
   logic [EW-1:0]   f_out_data;
   logic [CW-1:0]   f_count;

   ////////////////////////////////////////////////////////////////////////////
   // error protection: two parity-guarded copies, the good one wins

   function automatic logic [EW-1:0] ecc_enc(
      input logic [SW-1:0] d,
      input logic          s,
      input logic          b
   );
      logic [SW:0] c0;
      logic [SW:0] c1;
      c0 = {^d, d};
      c1 = {^d, d};
      c0[0] = c0[0] ^ (s | b);
      c1[0] = c1[0] ^ b;
      if (ECC) begin
         ecc_enc = EW'({c1, c0});
      end else begin
         ecc_enc = EW'(d);
      end
   endfunction

   function automatic logic copy_bad(
      input logic [SW:0] c
   );
      copy_bad = ^c;
   endfunction

   function automatic logic [SW:0] copy_sel(
      input logic [EW-1:0] w,
      input logic          hi
   );
      logic [2*(SW+1)-1:0] x;
      x = (2*(SW+1))'(w);
      copy_sel = hi ? x[2*(SW+1)-1:SW+1] : x[SW:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // storage

   dclq_fifo #(
      .W        (EW),
      .DEPTH    (DEPTH),
      .ASYNC_RS (ASYNC_RS)
   ) u_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (f_in_data),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data),
      .count     (f_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // write side: gather narrow pieces, push a whole word

   logic          w_last;
   logic          w_acc;
   logic [SW-1:0] w_word;

   assign w_last     = (st_q.wc == W_LAST);
   assign w_acc      = wr_en && (!w_last || f_in_ready);
   assign w_word     = st_q.asm_w | (SW'(wr_data) << (int'(st_q.wc) * WR_W));
   assign f_in_valid = ce && wr_en && w_last;
   assign f_in_data  = ecc_enc(w_word, inj_sbit, inj_dbit);

   ////////////////////////////////////////////////////////////////////////////
   // read side: decode, split wide words, choose request source

   logic [SW:0]     c_lo;
   logic [SW:0]     c_hi;
   logic            bad_lo;
   logic            bad_hi;
   logic [SW-1:0]   r_word;
   logic [RD_W-1:0] r_piece;
   logic            r_last;
   logic            req;
   logic            take;
   logic            ack;

   assign c_lo    = copy_sel(f_out_data, 1'b0);
   assign c_hi    = copy_sel(f_out_data, 1'b1);
   assign bad_lo  = ECC && copy_bad(c_lo);
   assign bad_hi  = ECC && copy_bad(c_hi);
   assign r_word  = !ECC ? SW'(f_out_data) : (bad_lo ? c_hi[SW-1:0] : c_lo[SW-1:0]);
   assign r_piece = RD_W'(r_word >> (int'(st_q.pc) * RD_W));
   assign r_last  = (st_q.pc == R_LAST);

   // foreign request: counted once the last two stages agree on a new high level
   assign req = INDEP_RD
      ? (st_q.sy[1] && st_q.sy[2] && !st_q.rq_lvl)
      : rd_en;

   // look-ahead refills when empty-handed or when the shown word is taken
   assign ack  = LOOK && req && st_q.hv;
   assign take = LOOK
      ? (f_out_valid && (!st_q.hv || ack))
      : (req && f_out_valid);
   assign f_out_ready = ce && take && r_last;

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_d = st_q;
      if (ce) begin
         // synchroniser chain for a request from the other timing domain
         st_d.sy = {st_q.sy[1:0], rd_en};
         if (st_q.sy[1] == st_q.sy[2]) begin
            st_d.rq_lvl = st_q.sy[2];
         end

         // write handshakes and packing
         st_d.wack = w_acc;
         st_d.ovf  = wr_en && !w_acc;
         if (w_acc) begin
            if (w_last) begin
               st_d.asm_w = '0;
               st_d.wc    = '0;
            end else begin
               st_d.asm_w = w_word;
               st_d.wc    = st_q.wc + 1'b1;
            end
         end

         // read path
         if (LOOK) begin
            if (take) begin
               st_d.hold = r_piece;
               st_d.hv   = 1'b1;
            end else if (ack) begin
               st_d.hv = 1'b0;
            end
            st_d.unf = req && !st_q.hv;
         end else begin
            st_d.hv = take;
            if (take) begin
               st_d.hold = r_piece;
            end
            st_d.unf = req && !f_out_valid;
         end
         if (take) begin
            st_d.pc  = r_last ? '0 : st_q.pc + 1'b1;
            st_d.sbe = bad_lo ^ bad_hi;
            st_d.dbe = bad_lo && bad_hi;
         end

         // extra pipeline stage in standard mode only
         st_d.dout = st_q.hold;
         st_d.vld  = st_q.hv;

         // status, one cycle behind the stored count, save look-ahead empty, which follows hv
         st_d.full   = (f_count == CW'(DEPTH));
         st_d.afull  = (f_count >= CW'(DEPTH - DCLQ_AFULL_GAP));
         st_d.empty  = LOOK ? !st_d.hv : (f_count == '0);
         st_d.aempty = (f_count <= CW'(DCLQ_AEMPTY_GAP));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   generate
      if (ASYNC_RS) begin : g_arst
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               st_q <= ST_RST;
            end else begin
               st_q <= st_d;
            end
         end
      end else begin : g_srst
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               st_q <= ST_RST;
            end else begin
               st_q <= st_d;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops; the mux is fixed at build time

   assign rd_data      = PIPE ? st_q.dout : st_q.hold;
   assign valid        = PIPE ? st_q.vld : st_q.hv;
   assign full         = st_q.full;
   assign almost_full  = st_q.afull;
   assign empty        = st_q.empty;
   assign almost_empty = st_q.aempty;
   assign wr_ack       = st_q.wack;
   assign overflow     = st_q.ovf;
   assign underflow    = st_q.unf;
   assign sbit_err     = st_q.sbe;
   assign dbit_err     = st_q.dbe;

endmodule

`default_nettype wire

// ### sim/dclq_top_sva.sv
// checker for the queue, written for the look-ahead read build
// assumes one clock; low ce or reset masks every check
`default_nettype none

module dclq_top_sva
   import dclq_pkg::*;
#(
   parameter int unsigned RD_W = DCLQ_DEF_RD_W
)(
   input wire logic            clk,
   input wire logic            rst_n,
   input wire logic            ce,
   input wire logic            wr_en,
   input wire logic            rd_en,
   input wire logic [RD_W-1:0] rd_data,
   input wire logic            valid,
   input wire logic            full,
   input wire logic            almost_full,
   input wire logic            empty,
   input wire logic            wr_ack,
   input wire logic            overflow,
   input wire logic            underflow
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n || !ce);

   ////////////////////////////////////////
   sequence s_wr_empty;
      empty && wr_en;
   endsequence
   sequence s_shown;
      valid && !rd_en;
   endsequence
   // full lags by a cycle, so a pop on the previous edge voids the check
   sequence s_wr_full;
      full && valid && wr_en && !rd_en && !$past(rd_en);
   endsequence

   AST_WR_ANSWER: assert property (wr_en |=> wr_ack != overflow)
      else $error("write got no single answer");
   AST_WR_QUIET: assert property (!wr_en |=> !wr_ack && !overflow)
      else $error("write answer without a write");
   AST_RD_REFUSE: assert property (rd_en && !valid |=> underflow)
      else $error("read with nothing shown not refused");
   AST_RD_TAKEN: assert property (rd_en && valid |=> !underflow)
      else $error("acknowledge of shown word refused");
   AST_HOLD: assert property (s_shown |=> valid && $stable(rd_data))
      else $error("shown word changed without acknowledge");
   AST_EMPTY_FLAG: assert property (empty == !valid)
      else $error("empty disagrees with valid");
   AST_FIRST: assert property (s_wr_empty |-> ##2 valid)
      else $error("first word not shown two cycles after write");
   AST_ROOM: assert property (!almost_full && wr_en |=> wr_ack)
      else $error("write refused with room left");
   AST_FULL_OVF: assert property (s_wr_full |=> overflow)
      else $error("write into full queue not refused");
endmodule

bind dclq_top dclq_top_sva #(.RD_W(RD_W)) dclq_top_sva_inst (.clk, .rst_n, .ce, .wr_en, .rd_en,
   .rd_data, .valid, .full, .almost_full, .empty, .wr_ack, .overflow, .underflow);

`default_nettype wire

// ### sim/dclq_user_model.sv
// read-side user logic of the look-ahead queue
// assumes valid and rd_data from the queue on the same clock
`default_nettype none

module dclq_user_model
   import dclq_pkg::*;
#(
   parameter int unsigned RD_W = DCLQ_DEF_RD_W
)(
   input  wire logic [1:0]      pace,
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            valid,
   input  wire logic [RD_W-1:0] rd_data,
   output logic                 rd_en,
   output logic                 got,
   output logic [RD_W-1:0]      got_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] tick_q;

   ////////////////////////////////////////
   // pace 0 stalls, 1 prompt, 2 every fourth cycle, 3 strobes blindly to provoke a refusal
   assign rd_en = (pace == 2'h3) || (valid && (pace == 2'h1 || (pace == 2'h2 && tick_q == 2'h0)));

   always @(posedge clk) begin
      tick_q   <= rst_n ? tick_q + 2'h1 : 2'h0;
      got      <= rst_n && rd_en && valid;
      got_data <= rd_data;
   end
endmodule

`default_nettype wire

// ### sim/dclq_tb_top.sv
// self-checking bench of the queue in look-ahead read mode
// assumes a 100 MHz clock and synchronous reset; ecc inputs stay idle
`default_nettype none

module dclq_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dclq_pkg::*;

   logic        clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, wr_p = 1'b0, ok_p = 1'b0;
   logic [1:0]  pace = 2'h0;
   logic [7:0]  wr_data = 8'h00, wd_p = 8'h00, rd_data, got_data;
   logic        rd_en, valid, full, almost_full, empty, almost_empty, wr_ack, overflow;
   logic        underflow, got, sbit_err, dbit_err, ce = 1'b1;
   logic [31:0] lfsr = 32'h99a4;
   logic [7:0]  ref_q[$];
   int          fails = 0, checked = 0, occ = 0;

   always #5 clk = ~clk;

   dclq_top #(.MODE(DCLQ_LOOK_AHEAD)) dclq_top_inst (.clk, .rst_n, .ce, .wr_en, .wr_data,
      .inj_sbit(1'b0), .inj_dbit(1'b0), .rd_en, .rd_data, .valid, .full, .almost_full, .empty,
      .almost_empty, .wr_ack, .overflow, .underflow, .sbit_err, .dbit_err);
   dclq_user_model dclq_user_model_inst (.pace, .clk, .rst_n, .valid, .rd_data, .rd_en, .got,
      .got_data);

   ////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // sixteen buffered words plus the one shown
   function automatic logic wr_fits(input int n);
      return n < 17;
   endfunction

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic drain();
      @(posedge clk);
      pace <= 2'h1;
      for (int i = 0; i < 80 && !(empty === 1'b1 && ref_q.size() == 0); i++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      pace <= 2'h0;
      #1 check({7'h0, empty}, 8'h1);
   endtask

   ////////////////////////////////////////
   // write answers and delivered words, judged against a reference queue
   always @(posedge clk) begin
      if (wr_p) check({6'h0, wr_ack, overflow}, ok_p ? 8'h2 : 8'h1);
      if (wr_p && ok_p) ref_q.push_back(wd_p);
      if (got) check(got_data, ref_q.pop_front());
      if (got) check({6'h0, sbit_err, dbit_err}, 8'h0);
      // a strobe seen while ce is low is neither answered nor stored
      wr_p <= wr_en && rst_n && ce;
      wd_p <= wr_data;
      ok_p <= wr_fits(occ);
      occ  <= !rst_n ? 0 : occ + int'(ce && wr_en && wr_fits(occ)) - int'(ce && rd_en && valid);
   end

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      #1 check({4'h0, empty, almost_empty, valid, full}, 8'hc);
      check(rd_data, 8'h00);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_data <= 8'h5a;
      @(posedge clk);
      wr_en <= 1'b0;
      #1 check({7'h0, valid}, 8'h0);
      @(posedge clk);
      #1 check(rd_data, 8'h5a);
      check({7'h0, valid}, 8'h1);
      // freeze: with ce low a write is neither answered nor stored, the word stays shown
      @(posedge clk);
      ce <= 1'b0;
      wr_en <= 1'b1;
      wr_data <= 8'ha5;
      repeat (2) @(posedge clk);
      wr_en <= 1'b0;
      #1 check({6'h0, wr_ack, valid}, 8'h1);
      check(rd_data, 8'h5a);
      // raise ce only after the strobe is gone, so no strobe meets the enabling edge
      @(posedge clk);
      ce <= 1'b1;
      drain();
      @(posedge clk);
      pace <= 2'h3;
      @(posedge clk);
      pace <= 2'h0;
      #1 check({7'h0, underflow}, 8'h1);
      // stalled reader: fill past the top, back to back
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         lfsr = next(lfsr);
         wr_en <= 1'b1;
         wr_data <= lfsr[7:0];
      end
      @(posedge clk);
      wr_en <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check({6'h0, full, almost_full}, 8'h3);
      drain();
      check({7'h0, almost_empty}, 8'h1);
      // sparse writes against a reader at least a quarter as fast, so never full
      for (int i = 0; i < 400; i++) begin
         @(posedge clk);
         lfsr = next(lfsr);
         wr_en <= lfsr[2:0] == 3'h0;
         wr_data <= lfsr[15:8];
         pace <= lfsr[5] ? 2'h1 : 2'h2;
      end
      @(posedge clk);
      wr_en <= 1'b0;
      drain();
      print_verdict();
   end

   // the whole run needs well under a thousand cycles
   initial begin
      #50000;
      fails++;
      print_verdict();
   end
endmodule

`default_nettype wire
